// ---- pcp_pkg.sv ----
// Constants and carrier types for the paged configuration and power-mode register block.
//
// Operation
// RULE1: Address 0x00 holds an eight-bit page selector on every page, and values 0 to 255 pick pages 0 to 255.
// RULE2: Writing one to bit 0 of the reset register returns every register to its power-on value; zero does nothing.
// RULE3: The software reset bit clears itself once the reset has been applied.
// RULE4: Bits 7 to 1 of the reset register are read-only, read as zero and take only zero from software.
// RULE5: Bits 5:4 of the reference register pick the quick-charge time of 3.5, 10, 50 or 100 ms.
// RULE6: Bit 3 of the reference register picks whether leaving sleep enables the reference with the regulator.
// RULE7: Bit 2 of the reference register picks internal analog regulation (0) or a direct 1.8 V analog supply (1).
// RULE8: Bit 1 picks the I/O supply mode, and software must not pick one while the I/O supply is above 2 V.
// RULE9: Bit 0 of the reference register is an active-low sleep control that resets to zero, so the part starts asleep.
// RULE10: Software writes only zeros into bits 7:6 of the reference register.
// RULE11: An analog supply above 2 V forces the analog supply mode to zero and raises a read-only flag.
// RULE12: An I/O supply above 2 V forces the I/O supply mode to zero and raises a read-only flag.
// RULE13: Addresses other than the page selector reach the page last written into it, and it reads back that value.
// RULE14: A software reset returns the page selector and the reference register to zero, as power-on reset does.
package pcp_pkg;

    // ----------------------------------------------------------------
    // Register offsets and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] PAGE_SELECT_OFFS = 8'h00;
    localparam logic [7:0] SOFT_RESET_OFFS = 8'h01;
    localparam logic [7:0] REF_CFG_OFFS = 8'h02;
    localparam logic [7:0] SUPPLY_STS_OFFS = 8'h03;
    localparam logic [7:0] PAGE_ZERO = 8'h00;
    localparam logic [7:0] PAGE_SELECT_RESET = 8'h00;
    localparam logic [7:0] REF_CFG_RESET = 8'h00;
    localparam logic SOFT_RESET_RESET = 1'b0;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int SOFT_RESET_BIT = 0;
    localparam int QCHG_LSB = 4;
    localparam int SLEEP_EXIT_REF_BIT = 3;
    localparam int ANALOG_MODE_BIT = 2;
    localparam int IO_MODE_BIT = 1;
    localparam int SLEEP_N_BIT = 0;
    localparam int ANALOG_FLAG_BIT = 7;
    localparam int IO_FLAG_BIT = 6;

    // ----------------------------------------------------------------
    // Quick-charge times
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int QCHG_TIME0_US = 3500;
    localparam int QCHG_TIME1_US = 10000;
    localparam int QCHG_TIME2_US = 50000;
    localparam int QCHG_TIME3_US = 100000;
    localparam int QCHG_CYC0 = (QCHG_TIME0_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int QCHG_CYC1 = (QCHG_TIME1_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int QCHG_CYC2 = (QCHG_TIME2_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int QCHG_CYC3 = (QCHG_TIME3_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // Page-0 register table
    // ----------------------------------------------------------------
    localparam int RW_N = 22;
    localparam logic [7:0] RW_OFFS [RW_N] = '{
        8'h42, 8'h43, 8'h4F, 8'h64, 8'h65, 8'h66, 8'h67, 8'h68, 8'h69, 8'h6A, 8'h6B,
        8'h6C, 8'h6D, 8'h6E, 8'h6F, 8'h70, 8'h71, 8'h73, 8'h76, 8'h77, 8'h78, 8'h7E};
    localparam logic [7:0] RW_RESET [RW_N] = '{
        8'h00, 8'h50, 8'h00, 8'h20, 8'h20, 8'h20, 8'hC9, 8'h80, 8'hC9, 8'h80, 8'h20,
        8'h20, 8'h20, 8'hC9, 8'h80, 8'hC9, 8'h80, 8'h18, 8'hCC, 8'h00, 8'h00, 8'h00};
    localparam int RO_N = 8;
    localparam logic [7:0] RO_OFFS [RO_N] = '{8'h3C, 8'h3D, 8'h3E, 8'h3F, 8'h40, 8'h41, 8'h79, 8'h7A};

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pcp_reg_req_t;

    typedef struct packed {
        logic [1:0] quick_charge_time;
        logic sleep_exit_ref_en;
        logic analog_supply_mode;
        logic io_supply_mode;
        logic sleep_active;
        logic digital_regulator_en;
        logic reference_en;
        logic quick_charge_active;
    } pcp_power_ctl_t;

    typedef logic [RO_N-1:0][7:0] pcp_ro_status_t;
    typedef logic [RW_N-1:0][7:0] pcp_cfg_regs_t;

endpackage

// ---- pcp_sync2.sv ----
// Two-stage synchroniser for levels entering the control clock domain.
`timescale 1ns/10ps
module pcp_sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// ---- pcp_qchg_timer.sv ----
// Quick-charge window timer with four selectable durations.
`timescale 1ns/10ps
module pcp_qchg_timer #(
    parameter int CYC0 = pcp_pkg::QCHG_CYC0,
    parameter int CYC1 = pcp_pkg::QCHG_CYC1,
    parameter int CYC2 = pcp_pkg::QCHG_CYC2,
    parameter int CYC3 = pcp_pkg::QCHG_CYC3,
    parameter int CNT_W = 32
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Control
    input wire logic start,
    input wire logic abort,
    input wire logic [1:0] sel,
    // Status
    output logic active
);
    logic [CNT_W-1:0] count_q;

    function automatic logic [CNT_W-1:0] load_value(input logic [1:0] s);
        case (s)
            2'd0: load_value = CNT_W'(CYC0 - 1);
            2'd1: load_value = CNT_W'(CYC1 - 1);
            2'd2: load_value = CNT_W'(CYC2 - 1);
            default: load_value = CNT_W'(CYC3 - 1);
        endcase
    endfunction

    // Abort wins so that a reference turned off mid-charge never leaves the charge path on.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= '0;
            active <= 1'b0;
        end else if (abort) begin
            count_q <= '0;
            active <= 1'b0;
        end else if (start) begin
            count_q <= load_value(sel);
            active <= 1'b1;
        end else if (active && count_q != '0) begin
            count_q <= count_q - CNT_W'(1);
        end else begin
            active <= 1'b0;
        end
    end
endmodule

// ---- pcp_paged_config_regs.sv ----
// Paged register bank with software reset and reference/power-mode control.
`timescale 1ns/10ps
module pcp_paged_config_regs #(
    parameter int QCHG_CYC0 = pcp_pkg::QCHG_CYC0,
    parameter int QCHG_CYC1 = pcp_pkg::QCHG_CYC1,
    parameter int QCHG_CYC2 = pcp_pkg::QCHG_CYC2,
    parameter int QCHG_CYC3 = pcp_pkg::QCHG_CYC3
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Register access from the control port
    input wire pcp_pkg::pcp_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_rd_valid,
    // Access forwarded to registers of other pages
    output pcp_pkg::pcp_reg_req_t page_req,
    output logic [7:0] page_sel,
    input wire logic [7:0] page_rdata,
    // Read-only status from neighbouring logic
    input wire pcp_pkg::pcp_ro_status_t ro_status,
    // Supply comparators, asynchronous to core_clk
    input wire logic analog_supply_high,
    input wire logic io_supply_high,
    // Power-mode controls and page-0 configuration
    output pcp_pkg::pcp_power_ctl_t power_ctl,
    output pcp_pkg::pcp_cfg_regs_t cfg_regs,
    output logic analog_supply_override_flag,
    output logic io_supply_override_flag
);

    // ----------------------------------------------------------------
    // Lookup functions
    // ----------------------------------------------------------------

    // Returns the table slot of a writable page-0 register, or RW_N when there is none.
    function automatic int rw_index(input logic [7:0] a);
        rw_index = pcp_pkg::RW_N;
        for (int i = 0; i < pcp_pkg::RW_N; i++) begin
            if (pcp_pkg::RW_OFFS[i] == a) begin
                rw_index = i;
            end
        end
    endfunction

    // Returns the slot of a read-only status register, or RO_N when there is none.
    function automatic int ro_index(input logic [7:0] a);
        ro_index = pcp_pkg::RO_N;
        for (int i = 0; i < pcp_pkg::RO_N; i++) begin
            if (pcp_pkg::RO_OFFS[i] == a) begin
                ro_index = i;
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [7:0] page_sel_q;
    logic soft_reset_bit_q;
    logic [7:0] ref_cfg_q;
    logic [7:0] cfg_q [pcp_pkg::RW_N];
    logic [7:0] rdata_q;
    logic rd_valid_q;
    logic page_rd_pend_q;
    pcp_pkg::pcp_reg_req_t page_req_q;
    pcp_pkg::pcp_power_ctl_t power_ctl_q;
    logic reference_en_q;
    logic analog_flag_q;
    logic io_flag_q;

    logic analog_high_s;
    logic io_high_s;
    logic qchg_active;

    logic addr_is_page;
    logic on_page_zero;
    logic local_hit;
    logic local_wr;
    logic local_rd;
    logic forward;
    logic soft_reset_req;
    logic [7:0] local_rdata;
    logic reference_en_d;
    logic qchg_start;
    int wr_slot;
    int rd_slot;
    int ro_slot;

    // ----------------------------------------------------------------
    // Supply comparator synchronisers
    // ----------------------------------------------------------------
    pcp_sync2 #(
        .WIDTH(2)
    ) u_supply_sync (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .async_in({analog_supply_high, io_supply_high}),
        .sync_out({analog_high_s, io_high_s})
    );

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    assign addr_is_page = (reg_req.addr == pcp_pkg::PAGE_SELECT_OFFS);
    assign on_page_zero = (page_sel_q == pcp_pkg::PAGE_ZERO);
    assign local_hit = addr_is_page || on_page_zero;  // see RULE13
    assign local_wr = reg_req.wr && local_hit;
    assign local_rd = reg_req.rd && local_hit;
    assign forward = (reg_req.wr || reg_req.rd) && !local_hit;  // see RULE13
    assign wr_slot = rw_index(reg_req.addr);
    assign rd_slot = rw_index(reg_req.addr);
    assign ro_slot = ro_index(reg_req.addr);

    // A write of one to the reset bit is taken only while page 0 is selected, and not
    // while a reset is already being applied, so the bit can never stick.
    assign soft_reset_req = local_wr && on_page_zero
        && (reg_req.addr == pcp_pkg::SOFT_RESET_OFFS)
        && reg_req.wdata[pcp_pkg::SOFT_RESET_BIT]
        && !soft_reset_bit_q;  // see RULE2

    // ----------------------------------------------------------------
    // Software reset
    // ----------------------------------------------------------------

    // The bit is high for exactly the one cycle in which the reset is applied.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            soft_reset_bit_q <= pcp_pkg::SOFT_RESET_RESET;
        end else if (soft_reset_req) begin
            soft_reset_bit_q <= 1'b1;  // see RULE2
        end else begin
            soft_reset_bit_q <= 1'b0;  // see RULE3
        end
    end

    // ----------------------------------------------------------------
    // Page selector
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            page_sel_q <= pcp_pkg::PAGE_SELECT_RESET;
        end else if (soft_reset_bit_q) begin
            page_sel_q <= pcp_pkg::PAGE_SELECT_RESET;  // see RULE14
        end else if (reg_req.wr && addr_is_page) begin
            page_sel_q <= reg_req.wdata;  // see RULE1
        end
    end

    // ----------------------------------------------------------------
    // Reference and power-mode register
    // ----------------------------------------------------------------

    // Reserved bits 7:6 are stored as written; software is expected to keep them zero.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ref_cfg_q <= pcp_pkg::REF_CFG_RESET;  // see RULE9
        end else if (soft_reset_bit_q) begin
            ref_cfg_q <= pcp_pkg::REF_CFG_RESET;  // see RULE14
        end else if (local_wr && on_page_zero && reg_req.addr == pcp_pkg::REF_CFG_OFFS) begin
            ref_cfg_q <= reg_req.wdata;
        end
    end

    // ----------------------------------------------------------------
    // Other page-0 configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < pcp_pkg::RW_N; i++) begin
                cfg_q[i] <= pcp_pkg::RW_RESET[i];
            end
        end else if (soft_reset_bit_q) begin
            for (int i = 0; i < pcp_pkg::RW_N; i++) begin
                cfg_q[i] <= pcp_pkg::RW_RESET[i];  // see RULE2
            end
        end else if (local_wr && on_page_zero && wr_slot < pcp_pkg::RW_N) begin
            cfg_q[wr_slot] <= reg_req.wdata;
        end
    end

    always_comb begin
        for (int i = 0; i < pcp_pkg::RW_N; i++) begin
            cfg_regs[i] = cfg_q[i];
        end
    end

    // ----------------------------------------------------------------
    // Supply override flags
    // ----------------------------------------------------------------

    // The flags follow the synchronised comparators; they are status, not sticky events.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            analog_flag_q <= 1'b0;
            io_flag_q <= 1'b0;
        end else begin
            analog_flag_q <= analog_high_s;  // see RULE11
            io_flag_q <= io_high_s;  // see RULE12
        end
    end

    // ----------------------------------------------------------------
    // Read data for page 0
    // ----------------------------------------------------------------
    always_comb begin
        local_rdata = 8'h00;
        if (addr_is_page) begin
            local_rdata = page_sel_q;  // see RULE13
        end else if (reg_req.addr == pcp_pkg::SOFT_RESET_OFFS) begin
            local_rdata[pcp_pkg::SOFT_RESET_BIT] = soft_reset_bit_q;  // see RULE4
        end else if (reg_req.addr == pcp_pkg::REF_CFG_OFFS) begin
            local_rdata = ref_cfg_q;
        end else if (reg_req.addr == pcp_pkg::SUPPLY_STS_OFFS) begin
            local_rdata[pcp_pkg::ANALOG_FLAG_BIT] = analog_flag_q;
            local_rdata[pcp_pkg::IO_FLAG_BIT] = io_flag_q;
        end else if (rd_slot < pcp_pkg::RW_N) begin
            local_rdata = cfg_q[rd_slot];
        end else if (ro_slot < pcp_pkg::RO_N) begin
            local_rdata = ro_status[ro_slot];
        end
    end

    // ----------------------------------------------------------------
    // Forwarding to other pages
    // ----------------------------------------------------------------

    // Registering the forwarded access costs a cycle but keeps the page ports glitch free.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            page_req_q <= '0;
        end else if (forward) begin
            page_req_q <= reg_req;  // see RULE13
        end else begin
            page_req_q <= '0;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            page_rd_pend_q <= 1'b0;
        end else begin
            page_rd_pend_q <= forward && reg_req.rd;
        end
    end

    // ----------------------------------------------------------------
    // Read answer
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= 8'h00;
            rd_valid_q <= 1'b0;
        end else if (local_rd) begin
            rdata_q <= local_rdata;
            rd_valid_q <= 1'b1;
        end else if (page_rd_pend_q) begin
            rdata_q <= page_rdata;
            rd_valid_q <= 1'b1;
        end else begin
            rd_valid_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Power-mode control
    // ----------------------------------------------------------------
    assign reference_en_d = ref_cfg_q[pcp_pkg::SLEEP_N_BIT]
        && ref_cfg_q[pcp_pkg::SLEEP_EXIT_REF_BIT];  // see RULE6
    assign qchg_start = reference_en_d && !reference_en_q;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            reference_en_q <= 1'b0;
        end else begin
            reference_en_q <= reference_en_d;
        end
    end

    pcp_qchg_timer #(
        .CYC0(QCHG_CYC0),
        .CYC1(QCHG_CYC1),
        .CYC2(QCHG_CYC2),
        .CYC3(QCHG_CYC3),
        .CNT_W(32)
    ) u_qchg_timer (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .start(qchg_start),
        .abort(!reference_en_d),
        .sel(ref_cfg_q[pcp_pkg::QCHG_LSB +: 2]),  // see RULE5
        .active(qchg_active)
    );

    // A supply above 2 V overrides the programmed mode whatever software wrote.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            power_ctl_q <= '0;
            power_ctl_q.sleep_active <= 1'b1;
        end else begin
            power_ctl_q.quick_charge_time <= ref_cfg_q[pcp_pkg::QCHG_LSB +: 2];  // see RULE5
            power_ctl_q.sleep_exit_ref_en <= ref_cfg_q[pcp_pkg::SLEEP_EXIT_REF_BIT];
            power_ctl_q.analog_supply_mode <= ref_cfg_q[pcp_pkg::ANALOG_MODE_BIT]
                && !analog_high_s;  // see RULE7, RULE11
            power_ctl_q.io_supply_mode <= ref_cfg_q[pcp_pkg::IO_MODE_BIT]
                && !io_high_s;  // see RULE8, RULE12
            power_ctl_q.sleep_active <= !ref_cfg_q[pcp_pkg::SLEEP_N_BIT];  // see RULE9
            power_ctl_q.digital_regulator_en <= ref_cfg_q[pcp_pkg::SLEEP_N_BIT];  // see RULE6
            power_ctl_q.reference_en <= reference_en_d;
            power_ctl_q.quick_charge_active <= qchg_active;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign reg_rdata = rdata_q;
    assign reg_rd_valid = rd_valid_q;
    assign page_req = page_req_q;
    assign page_sel = page_sel_q;
    assign power_ctl = power_ctl_q;
    assign analog_supply_override_flag = analog_flag_q;
    assign io_supply_override_flag = io_flag_q;

endmodule

// ---- pcp_paged_config_regs_props.sv ----
// Port-level checker for the paged configuration register block.
`timescale 1ns/10ps
module pcp_paged_config_regs_chk (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Register port
    input wire pcp_pkg::pcp_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rd_valid,
    // Other pages
    input wire pcp_pkg::pcp_reg_req_t page_req,
    input wire logic [7:0] page_sel,
    input wire logic [7:0] page_rdata,
    // Supplies and power controls
    input wire logic analog_supply_high,
    input wire logic io_supply_high,
    input wire pcp_pkg::pcp_power_ctl_t power_ctl,
    input wire logic analog_supply_override_flag,
    input wire logic io_supply_override_flag
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    logic sr_hit;
    logic sr_q;
    logic local_rd;
    assign sr_hit = reg_req.wr && reg_req.addr == 8'h01 && reg_req.wdata[0] && page_sel == 8'h00;
    assign local_rd = reg_req.rd && (reg_req.addr == 8'h00 || page_sel == 8'h00);
    // Marks the soft reset cycle, in which writes are lost.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sr_q <= 1'b0;
        end else begin
            sr_q <= sr_hit;
        end
    end
    AST_LOCAL_RD: assert property (local_rd |=> reg_rd_valid)
        else $error("Read late.");
    AST_FWD_RD: assert property (reg_req.rd && !local_rd |=> page_req.rd && page_req.addr == $past(reg_req.addr)
        ##1 reg_rd_valid && reg_rdata == $past(page_rdata)) else $error("Forwarded read wrong.");
    AST_PAGE_WR: assert property (reg_req.wr && reg_req.addr == 8'h00 && !sr_q |=> page_sel == $past(reg_req.wdata))
        else $error("Page not set.");
    AST_SLEEP: assert property (reg_req.wr && reg_req.addr == 8'h02 && page_sel == 8'h00 && !sr_q
        |=> ##1 power_ctl.sleep_active == !$past(reg_req.wdata[0], 2)) else $error("Sleep control wrong.");
    AST_REG_EN: assert property (power_ctl.digital_regulator_en == !power_ctl.sleep_active
        && power_ctl.reference_en == (!power_ctl.sleep_active && power_ctl.sleep_exit_ref_en)) else $error("Enables wrong.");
    AST_ANA_FORCE: assert property (analog_supply_high [*5] |-> analog_supply_override_flag
        && !power_ctl.analog_supply_mode) else $error("Analog not forced.");
    AST_IO_FLAG: assert property (io_supply_high [*5] |-> io_supply_override_flag)
        else $error("I/O flag missing.");
    AST_IO_FORCE: assert property (io_supply_override_flag |-> !power_ctl.io_supply_mode)
        else $error("I/O mode not forced.");
    AST_SOFT_RST: assert property (sr_q |=> page_sel == 8'h00 ##1 power_ctl.sleep_active)
        else $error("No soft reset.");
    AST_QCHG: assert property ($rose(power_ctl.reference_en) |-> ##[0:2] power_ctl.quick_charge_active)
        else $error("No quick charge.");
endmodule
bind pcp_paged_config_regs pcp_paged_config_regs_chk i_chk (.core_clk(core_clk), .arst_n(arst_n),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .page_req(page_req),
    .page_sel(page_sel), .page_rdata(page_rdata), .analog_supply_high(analog_supply_high),
    .io_supply_high(io_supply_high), .power_ctl(power_ctl),
    .analog_supply_override_flag(analog_supply_override_flag), .io_supply_override_flag(io_supply_override_flag));

// ---- testbench.sv ----
// Self-checking testbench for the paged configuration register block.
`timescale 1ns/10ps
module testbench;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    pcp_pkg::pcp_reg_req_t reg_req = '0;
    logic [7:0] reg_rdata;
    logic reg_rd_valid;
    pcp_pkg::pcp_reg_req_t page_req;
    logic [7:0] page_sel;
    logic [7:0] page_rdata = 8'h00;
    pcp_pkg::pcp_ro_status_t ro_status;
    logic analog_supply_high = 1'b0;
    logic io_supply_high = 1'b0;
    pcp_pkg::pcp_power_ctl_t power_ctl;
    pcp_pkg::pcp_cfg_regs_t cfg_regs;
    logic ana_flag;
    logic io_flag;
    int bad_count = 0;
    int tests_run = 0;
    int cycles = 0;

    always #25 core_clk = ~core_clk;

    pcp_paged_config_regs #(.QCHG_CYC0(4), .QCHG_CYC1(6), .QCHG_CYC2(8), .QCHG_CYC3(10)) i_dut (
        .core_clk(core_clk), .arst_n(arst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .reg_rd_valid(reg_rd_valid), .page_req(page_req), .page_sel(page_sel), .page_rdata(page_rdata),
        .ro_status(ro_status), .analog_supply_high(analog_supply_high), .io_supply_high(io_supply_high),
        .power_ctl(power_ctl), .cfg_regs(cfg_regs), .analog_supply_override_flag(ana_flag),
        .io_supply_override_flag(io_flag));

    // ----
    // Bus tasks and comparison
    // ----
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge core_clk);
        reg_req = '0;
    endtask
    task automatic expect_rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge core_clk);
        reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge core_clk);
        reg_req = '0;
        repeat (2) if (reg_rd_valid !== 1'b1) @(negedge core_clk);
        chk(reg_rd_valid === 1'b1 ? reg_rdata : 8'hxx, exp);
    endtask

    // ----
    // Scenarios
    // ----
    task automatic t_reset_map;
        expect_rd(8'h00, 8'h00);
        expect_rd(8'h01, 8'h00);
        expect_rd(8'h02, 8'h00);
        chk(8'(power_ctl.sleep_active), 8'h01);
        for (int i = 0; i < pcp_pkg::RW_N; i++) begin
            expect_rd(pcp_pkg::RW_OFFS[i], pcp_pkg::RW_RESET[i]);
        end
        for (int i = 0; i < pcp_pkg::RO_N; i++) begin
            wr(pcp_pkg::RO_OFFS[i], 8'hff);
            expect_rd(pcp_pkg::RO_OFFS[i], 8'(17 * (i + 1)));
        end
        wr(8'h50, 8'h5a);
        expect_rd(8'h50, 8'h00);
        $display("Test reset_map done");
    endtask
    task automatic t_page;
        wr(8'h00, 8'h05);
        expect_rd(8'h00, 8'h05);
        page_rdata = 8'h3c;
        expect_rd(8'h10, 8'h3c);
        wr(8'h01, 8'h01);
        chk(8'(page_req.wr), 8'h01);
        chk(page_req.addr, 8'h01);
        chk(page_sel, 8'h05);
        wr(8'h00, 8'hff);
        expect_rd(8'h00, 8'hff);
        wr(8'h00, 8'h00);
        expect_rd(8'h43, 8'h50);
        $display("Test page done");
    endtask
    task automatic t_ref;
        int n;
        for (int c = 0; c < 4; c++) begin
            wr(8'h02, 8'h00);
            wr(8'h02, {2'b00, 2'(c), 4'b1001});
            n = 0;
            for (int k = 0; k < 20; k++) begin
                @(negedge core_clk);
                n += int'(power_ctl.quick_charge_active === 1'b1);
            end
            chk(8'(power_ctl.quick_charge_time), 8'(c));
            chk(8'(n >= 4 + 2 * c && n <= 5 + 2 * c), 8'h01);
            chk(8'(power_ctl.reference_en), 8'h01);
        end
        wr(8'h02, 8'h01);
        @(negedge core_clk);
        chk(8'(power_ctl[2:1]), 8'h02);
        $display("Test ref done");
    endtask
    task automatic t_supply;
        wr(8'h02, 8'h07);
        @(negedge core_clk);
        chk(8'(power_ctl[5:4]), 8'h03);
        analog_supply_high = 1'b1;
        repeat (5) @(negedge core_clk);
        chk(8'(power_ctl[5:4]), 8'h01);
        expect_rd(8'h03, 8'h80);
        io_supply_high = 1'b1;
        repeat (5) @(negedge core_clk);
        chk(8'(power_ctl[5:4]), 8'h00);
        expect_rd(8'h03, 8'hc0);
        analog_supply_high = 1'b0;
        io_supply_high = 1'b0;
        repeat (5) @(negedge core_clk);
        expect_rd(8'h03, 8'h00);
        expect_rd(8'h02, 8'h07);
        $display("Test supply done");
    endtask
    task automatic t_soft;
        wr(8'h43, 8'haa);
        wr(8'h02, 8'h09);
        wr(8'h01, 8'h00);
        expect_rd(8'h43, 8'haa);
        wr(8'h01, 8'h01);
        @(negedge core_clk);
        expect_rd(8'h01, 8'h00);
        expect_rd(8'h43, 8'h50);
        expect_rd(8'h02, 8'h00);
        expect_rd(8'h00, 8'h00);
        chk(8'(power_ctl.sleep_active), 8'h01);
        $display("Test soft done");
    endtask

    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            stop_test();
        end
    end

    initial begin
        for (int i = 0; i < pcp_pkg::RO_N; i++) begin
            ro_status[i] = 8'(17 * (i + 1));
        end
        repeat (4) @(negedge core_clk);
        arst_n = 1'b1;
        t_reset_map();
        t_page();
        t_ref();
        t_supply();
        t_soft();
        stop_test();
    end
endmodule
